// File: include/lpm_irq_defines.vh
`ifndef LPM_IRQ_DEFINES_VH
`define LPM_IRQ_DEFINES_VH

// register indices; all are even, and each register sits at four times its index
`define IDX_SYSTEM_CONTROL_TWO 16'hfff2
`define IDX_KEY_INTERRUPT_ENABLE 16'hfff6
`define IDX_KEY_INTERRUPT_REQUEST_FLAGS 16'hfff8
`define IDX_REQUEST_FLAGS_ONE 16'hfffc
`define IDX_IRQ_STATUS 16'hffe0
`define IDX_IRQ_MASK 16'hffe4
`define IDX_MODE_CONTROL 16'hffe8
`define IDX_MODE_STATUS 16'hffec
`define IDX_TIMER_B1_COUNT 16'hfff0

// byte addresses on the register bus
`define ADDR_SYSTEM_CONTROL_TWO {`IDX_SYSTEM_CONTROL_TWO, 2'b00}
`define ADDR_KEY_INTERRUPT_ENABLE {`IDX_KEY_INTERRUPT_ENABLE, 2'b00}
`define ADDR_KEY_INTERRUPT_REQUEST_FLAGS {`IDX_KEY_INTERRUPT_REQUEST_FLAGS, 2'b00}
`define ADDR_REQUEST_FLAGS_ONE {`IDX_REQUEST_FLAGS_ONE, 2'b00}
`define ADDR_IRQ_STATUS {`IDX_IRQ_STATUS, 2'b00}
`define ADDR_IRQ_MASK {`IDX_IRQ_MASK, 2'b00}
`define ADDR_MODE_CONTROL {`IDX_MODE_CONTROL, 2'b00}
`define ADDR_MODE_STATUS {`IDX_MODE_STATUS, 2'b00}
`define ADDR_TIMER_B1_COUNT {`IDX_TIMER_B1_COUNT, 2'b00}
`define ADDR_WIDTH 18

// system_control_two fields
`define SYSCTL2_RESET 8'he0
`define SYSCTL2_RESERVED 8'he0
`define BIT_SUB_CLOCK_DIV_LO 0
`define BIT_SUB_CLOCK_DIV_HI 1
`define BIT_MEDIUM_SPEED_SELECT 2
`define BIT_DIRECT_TRANSFER_ENABLE 3
`define BIT_NOISE_FILTER_RATE_SEL 4

// request_flags_one fields
`define BIT_TIMER_B1_OVERFLOW_FLAG 0
`define BIT_DIRECT_TRANSFER_FLAG 1

// mode_control fields (sleep-time selects)
`define BIT_STANDBY_SELECT 0
`define BIT_LOW_SPEED_SELECT 1
`define BIT_TIMER_A_CLOCK_SOURCE_BIT 2

// operating modes
`define MODE_ACTIVE_HIGH 3'h0
`define MODE_ACTIVE_MEDIUM 3'h1
`define MODE_SUBACTIVE 3'h2
`define MODE_SLEEP 3'h3
`define MODE_STANDBY 3'h4
`define MODE_WATCH 3'h5

// noise filter sample dividers
`define NOISE_DIV_SLOW 16
`define NOISE_DIV_FAST 4
`define NOISE_CNT_W 4

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: verilog/pin_edge_filter.v
`timescale 1ns/100ps
`include "lpm_irq_defines.vh"

// samples each pin on the divided tick, needs two equal samples, flags the chosen edge
module pin_edge_filter #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // control
  input wire fast_rate,
  input wire [WIDTH-1:0] rising_sel,
  // pins and detected edges
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] edge_pulse
);

  reg [`NOISE_CNT_W-1:0] div_cnt;
  reg [WIDTH-1:0] sample_a;
  reg [WIDTH-1:0] sample_b;
  reg [WIDTH-1:0] clean;
  wire tick;

  assign tick = fast_rate ? (div_cnt[1:0] == 2'h3) : (div_cnt == 4'hf);

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      always @(posedge aclk) begin
        if (!aresetn) begin
          sample_a[i] <= 1'b0;
          sample_b[i] <= 1'b0;
          clean[i] <= 1'b0;
          edge_pulse[i] <= 1'b0;
        end else begin
          edge_pulse[i] <= 1'b0;
          if (tick) begin
            sample_a[i] <= pin_in[i];
            sample_b[i] <= sample_a[i];
            // a level must hold across two samples before it counts
            if (sample_a[i] == sample_b[i] && sample_a[i] != clean[i]) begin
              clean[i] <= sample_a[i];
              edge_pulse[i] <= (sample_a[i] == rising_sel[i]);
            end
          end
        end
      end
    end
  endgenerate

endmodule

// File: verilog/low_power_mode_and_irq_flags.v
`timescale 1ns/100ps
`include "lpm_irq_defines.vh"

module low_power_mode_and_irq_flags #(
  parameter PINS = 8
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [`ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [`ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // cpu and pins
  input wire sleep_exec,
  input wire wake_event,
  input wire [PINS-1:0] key_pin,
  input wire [PINS-1:0] key_rising_sel,
  // mode, clock and interrupt outputs
  output reg [2:0] op_mode,
  output reg [1:0] sub_clock_div,
  output reg [PINS-1:0] key_irq_to_cpu,
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg [4:0] sysctl2;
  reg [PINS-1:0] key_enable;
  reg [PINS-1:0] key_flags;
  reg tb1_flag;
  reg dt_flag;
  reg [2:0] mode_ctl;
  reg [7:0] tb1_count;
  reg [3:0] irq_status;
  reg [3:0] irq_mask;
  // flags seen as 1 by the last read, so a clear needs a prior read
  reg [PINS-1:0] key_seen;
  reg tb1_seen;
  reg dt_seen;
  reg [`ADDR_WIDTH-1:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg w_held;
  reg w_lane;
  reg [2:0] next_mode;
  reg direct_move;
  wire [PINS-1:0] key_edge;
  wire tb1_wrap;
  wire do_write;
  wire do_read;
  wire wr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // pin edge detection with noise filter

  pin_edge_filter #(
    .WIDTH(PINS)
  ) u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .fast_rate(sysctl2[`BIT_NOISE_FILTER_RATE_SEL]),
    .rising_sel(key_rising_sel),
    .pin_in(key_pin),
    .edge_pulse(key_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write channel capture

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok = w_lane;
  assign do_read = s_axi_arvalid && s_axi_arready;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {`ADDR_WIDTH{1'b0}};
      w_data <= 32'h0000_0000;
      w_lane <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_lane <= s_axi_wstrb[0];
        w_data <= {s_axi_wdata[31:8], s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00};
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `ADDR_SYSTEM_CONTROL_TWO, `ADDR_KEY_INTERRUPT_ENABLE,
          `ADDR_KEY_INTERRUPT_REQUEST_FLAGS, `ADDR_REQUEST_FLAGS_ONE,
          `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK, `ADDR_MODE_CONTROL,
          `ADDR_MODE_STATUS, `ADDR_TIMER_B1_COUNT: s_axi_bresp <= `RESP_OKAY;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always @(posedge aclk) begin
    if (!aresetn) begin
      sysctl2 <= 5'h00;
      key_enable <= {PINS{1'b0}};
      mode_ctl <= 3'h0;
      irq_mask <= 4'h0;
    end else if (do_write && wr_ok) begin
      case (aw_addr)
        `ADDR_SYSTEM_CONTROL_TWO: sysctl2 <= w_data[4:0];
        `ADDR_KEY_INTERRUPT_ENABLE: key_enable <= w_data[PINS-1:0];
        `ADDR_MODE_CONTROL: mode_ctl <= w_data[2:0];
        `ADDR_IRQ_MASK: irq_mask <= w_data[3:0];
        default: mode_ctl <= mode_ctl;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer b1 counter, software-loadable

  assign tb1_wrap = (tb1_count == 8'hff);

  always @(posedge aclk) begin
    if (!aresetn) begin
      tb1_count <= 8'h00;
    end else if (do_write && wr_ok && aw_addr == `ADDR_TIMER_B1_COUNT) begin
      tb1_count <= w_data[7:0];
    end else begin
      tb1_count <= tb1_count + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencer

  always @* begin
    next_mode = op_mode;
    direct_move = 1'b0;
    case (op_mode)
      `MODE_ACTIVE_HIGH, `MODE_ACTIVE_MEDIUM: begin
        if (sleep_exec) begin
          if (sysctl2[`BIT_DIRECT_TRANSFER_ENABLE]) begin
            if (mode_ctl[`BIT_STANDBY_SELECT] && mode_ctl[`BIT_TIMER_A_CLOCK_SOURCE_BIT]
                && mode_ctl[`BIT_LOW_SPEED_SELECT]) begin
              next_mode = `MODE_SUBACTIVE;
            end else if (!mode_ctl[`BIT_STANDBY_SELECT]) begin
              next_mode = sysctl2[`BIT_MEDIUM_SPEED_SELECT] ?
                          `MODE_ACTIVE_MEDIUM : `MODE_ACTIVE_HIGH;
            end else begin
              next_mode = `MODE_SLEEP;
            end
            direct_move = (next_mode != `MODE_SLEEP) && (next_mode != op_mode);
          end else if (mode_ctl[`BIT_STANDBY_SELECT]) begin
            next_mode = mode_ctl[`BIT_TIMER_A_CLOCK_SOURCE_BIT] ? `MODE_WATCH : `MODE_STANDBY;
          end else begin
            next_mode = `MODE_SLEEP;
          end
        end
      end
      `MODE_SUBACTIVE: begin
        if (sleep_exec) begin
          if (sysctl2[`BIT_DIRECT_TRANSFER_ENABLE]
              && !mode_ctl[`BIT_LOW_SPEED_SELECT]) begin
            next_mode = sysctl2[`BIT_MEDIUM_SPEED_SELECT] ?
                        `MODE_ACTIVE_MEDIUM : `MODE_ACTIVE_HIGH;
            direct_move = 1'b1;
          end else begin
            next_mode = `MODE_WATCH;
          end
        end
      end
      `MODE_SLEEP, `MODE_STANDBY, `MODE_WATCH: begin
        if (wake_event) begin
          next_mode = sysctl2[`BIT_MEDIUM_SPEED_SELECT] ?
                      `MODE_ACTIVE_MEDIUM : `MODE_ACTIVE_HIGH;
        end
      end
      default: next_mode = `MODE_ACTIVE_HIGH;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // request flags: set beats clear, clear needs a 1 read first

  always @(posedge aclk) begin
    if (!aresetn) begin
      key_flags <= {PINS{1'b0}};
      tb1_flag <= 1'b0;
      dt_flag <= 1'b0;
      irq_status <= 4'h0;
      op_mode <= `MODE_ACTIVE_HIGH;
      sub_clock_div <= 2'h0;
      key_irq_to_cpu <= {PINS{1'b0}};
      irq <= 1'b0;
    end else begin
      op_mode <= next_mode;
      sub_clock_div <= {sysctl2[`BIT_SUB_CLOCK_DIV_HI], sysctl2[`BIT_SUB_CLOCK_DIV_LO]};
      // only write-0 clears; a written 1 keeps the flag
      if (do_write && wr_ok && aw_addr == `ADDR_KEY_INTERRUPT_REQUEST_FLAGS) begin
        key_flags <= (key_flags & ~(key_seen & ~w_data[PINS-1:0])) | key_edge;
      end else begin
        key_flags <= key_flags | key_edge;
      end
      if (tb1_wrap) begin
        tb1_flag <= 1'b1;
      end else if (do_write && wr_ok && aw_addr == `ADDR_REQUEST_FLAGS_ONE
                   && tb1_seen && !w_data[`BIT_TIMER_B1_OVERFLOW_FLAG]) begin
        tb1_flag <= 1'b0;
      end
      if (direct_move) begin
        dt_flag <= 1'b1;
      end else if (do_write && wr_ok && aw_addr == `ADDR_REQUEST_FLAGS_ONE
                   && dt_seen && !w_data[`BIT_DIRECT_TRANSFER_FLAG]) begin
        dt_flag <= 1'b0;
      end
      // sticky summary events, write one to clear
      if (do_write && wr_ok && aw_addr == `ADDR_IRQ_STATUS) begin
        irq_status <= (irq_status & ~w_data[3:0]) |
                      {|(key_edge & key_enable), direct_move, tb1_wrap, |key_edge};
      end else begin
        irq_status <= irq_status |
                      {|(key_edge & key_enable), direct_move, tb1_wrap, |key_edge};
      end
      key_irq_to_cpu <= key_flags & key_enable;
      irq <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel; reading a flag register arms clearing of the ones seen

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
      key_seen <= {PINS{1'b0}};
      tb1_seen <= 1'b0;
      dt_seen <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      // a write to the same flag register spends the read, so a stale read never arms a later clear
      if (do_write && aw_addr == `ADDR_KEY_INTERRUPT_REQUEST_FLAGS) begin
        key_seen <= {PINS{1'b0}};
      end
      if (do_write && aw_addr == `ADDR_REQUEST_FLAGS_ONE) begin
        tb1_seen <= 1'b0;
        dt_seen <= 1'b0;
      end
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr)
          `ADDR_SYSTEM_CONTROL_TWO: s_axi_rdata[7:0] <= `SYSCTL2_RESERVED | {3'h0, sysctl2};
          `ADDR_KEY_INTERRUPT_ENABLE: s_axi_rdata[PINS-1:0] <= key_enable;
          `ADDR_KEY_INTERRUPT_REQUEST_FLAGS: begin
            s_axi_rdata[PINS-1:0] <= key_flags;
            key_seen <= key_flags;
          end
          `ADDR_REQUEST_FLAGS_ONE: begin
            s_axi_rdata[1:0] <= {dt_flag, tb1_flag};
            tb1_seen <= tb1_flag;
            dt_seen <= dt_flag;
          end
          `ADDR_IRQ_STATUS: s_axi_rdata[3:0] <= irq_status;
          `ADDR_IRQ_MASK: s_axi_rdata[3:0] <= irq_mask;
          `ADDR_MODE_CONTROL: s_axi_rdata[2:0] <= mode_ctl;
          `ADDR_MODE_STATUS: s_axi_rdata[2:0] <= op_mode;
          `ADDR_TIMER_B1_COUNT: s_axi_rdata[7:0] <= tb1_count;
          default: s_axi_rresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// File: tb/lpm_irq_props.sv
`timescale 1ns/100ps
`include "lpm_irq_defines.vh"
module lpm_irq_props (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus handshakes
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // mode control
  input wire sleep_exec,
  input wire wake_event,
  input wire [2:0] op_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////
  sequence s_wr_taken;
    s_axi_awready && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    ##2 s_axi_bvalid;
  endsequence
  property p_wr_resp;
    s_wr_taken |-> s_wr_answer;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read data late");
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write response repeated");
  property p_r_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read data repeated");
  property p_aw_pulse;
    s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready too long");
  property p_w_pulse;
    s_axi_wready |=> !s_axi_wready;
  endproperty
  a_w_pulse: assert property (p_w_pulse) else $error("wready too long");
  property p_bresp;
    s_axi_bvalid |-> (s_axi_bresp == `RESP_OKAY || s_axi_bresp == `RESP_SLVERR);
  endproperty
  a_bresp: assert property (p_bresp) else $error("bad write response code");
  // mode may only move on a sleep or a wake from the cpu
  property p_mode;
    !$stable(op_mode) |-> $past(sleep_exec) || $past(wake_event);
  endproperty
  a_mode: assert property (p_mode) else $error("mode moved on its own");
endmodule
bind low_power_mode_and_irq_flags lpm_irq_props u_props (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .sleep_exec, .wake_event, .op_mode);

// File: tb/tb.sv
`timescale 1ns/100ps
`include "lpm_irq_defines.vh"
module tb;
  localparam logic [1:0] ok = `RESP_OKAY;
  localparam logic [1:0] se = `RESP_SLVERR;
  localparam logic [17:0] sys_a = `ADDR_SYSTEM_CONTROL_TWO;
  localparam logic [17:0] ken_a = `ADDR_KEY_INTERRUPT_ENABLE;
  localparam logic [17:0] kf_a = `ADDR_KEY_INTERRUPT_REQUEST_FLAGS;
  localparam logic [17:0] rf_a = `ADDR_REQUEST_FLAGS_ONE;
  localparam logic [17:0] st_a = `ADDR_IRQ_STATUS;
  localparam logic [17:0] msk_a = `ADDR_IRQ_MASK;
  localparam logic [17:0] mc_a = `ADDR_MODE_CONTROL;
  localparam logic [17:0] cnt_a = `ADDR_TIMER_B1_COUNT;
  logic aclk = 0;
  logic aresetn = 0;
  logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, sleep_exec = 0, wake_event = 0;
  logic [7:0] key_pin = 0, key_rising_sel = 0, key_irq_to_cpu;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, sub_clock_div;
  logic [31:0] s_axi_rdata, v, en, m, sel;
  logic [2:0] op_mode;
  // sleep steps: select reg, mode control, sleep or wake, expected mode
  logic [15:0] steps [7] = '{16'h000b, 16'h0000, 16'h040b, 16'h0401, 16'h0808, 16'h0c09, 16'h097a};
  int err_total = 0;
  int checked = 0;
  logic [31:0] seed = 32'd65259;
  always #4 aclk = ~aclk;
  low_power_mode_and_irq_flags u_low_power_mode_and_irq_flags (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_exec, .wake_event,
    .key_pin, .key_rising_sel, .op_mode, .sub_clock_div, .key_irq_to_cpu, .irq);
  //////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task tally_and_finish;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task limit(input int n);
    if (n >= 50) begin
      err_total++;
      $display("BAD bus_wait exp 50 got %0d", n);
      tally_and_finish();
    end
  endtask
  task wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 0;
    limit(n);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  // empty name reads only to arm a flag clear
  task rd(input logic [17:0] a, input logic [31:0] e, input logic [1:0] er, input string nm);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 0;
    limit(n);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    if (nm != "" && er == ok) chk(nm, e, s_axi_rdata);
  endtask
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  //////////////////////////////////////////
  initial begin
    tick(20);
    aresetn <= 1;
    tick(1);
    rd(sys_a, 32'he0, ok, "sysctl2");
    rd(ken_a, 0, ok, "key_en");
    rd(kf_a, 0, ok, "key_flags");
    wr(18'h00100, 32'h5a, se);
    rd(18'h00100, 0, se, "unmapped");
    v = rnd();
    wr(sys_a, v, ok);
    rd(sys_a, {24'h0, v[7:0] | 8'he0}, ok, "sysctl2");
    chk("sub_div", {30'h0, v[1:0]}, {30'h0, sub_clock_div});
    wr(sys_a, 0, ok);
    $display("test registers done");
    wr(cnt_a, 0, ok);
    rd(rf_a, 0, ok, "tb1_flag");
    tick(230);
    rd(rf_a, 0, ok, "tb1_flag");
    tick(30);
    rd(rf_a, 1, ok, "tb1_flag");
    wr(rf_a, 32'hff, ok);
    rd(rf_a, 1, ok, "tb1_flag");
    wr(rf_a, 0, ok);
    rd(rf_a, 0, ok, "tb1_flag");
    for (int i = 0; i < 4; i++) begin
      // mask off, mask wrap bit, clear wrap status, mask off again
      wr(i == 2 ? st_a : msk_a, {30'h0, i[0] ^ i[1], 1'b0}, ok);
      tick(2);
      chk("irq", {31'h0, i[0] & ~i[1]}, {31'h0, irq});
    end
    $display("test timer and irq done");
    for (int r = 0; r < 2; r++) begin
      en = rnd() | 1;
      m = rnd() | 1;
      sel = rnd();
      wr(sys_a, r ? 32'h10 : 32'h0, ok);
      wr(ken_a, {24'h0, en[7:0]}, ok);
      rd(ken_a, {24'h0, en[7:0]}, ok, "key_en");
      key_rising_sel <= sel[7:0];
      key_pin <= ~sel[7:0];
      tick(100);
      rd(kf_a, 0, ok, "");
      wr(kf_a, 0, ok);
      key_pin <= ~sel[7:0] ^ m[7:0];
      tick(12);
      if (r == 0) chk("slow_irq", 0, {24'h0, key_irq_to_cpu});
      tick(12);
      if (r == 1) chk("fast_irq", m & en & 32'hff, {24'h0, key_irq_to_cpu});
      tick(80);
      chk("key_irq", m & en & 32'hff, {24'h0, key_irq_to_cpu});
      rd(kf_a, m & 32'hff, ok, "key_flags");
      wr(kf_a, 32'hff, ok);
      rd(kf_a, m & 32'hff, ok, "key_flags");
      wr(kf_a, 0, ok);
      rd(kf_a, 0, ok, "key_flags");
    end
    $display("test key pins done");
    wr(cnt_a, 0, ok);
    rd(rf_a, 0, ok, "");
    wr(rf_a, 0, ok);
    foreach (steps[i]) begin
      wr(sys_a, {24'h0, steps[i][15:8]}, ok);
      wr(mc_a, {28'h0, steps[i][7:4]}, ok);
      sleep_exec <= steps[i][3];
      wake_event <= ~steps[i][3];
      tick(1);
      sleep_exec <= 0;
      wake_event <= 0;
      tick(2);
      chk("op_mode", {29'h0, steps[i][2:0]}, {29'h0, op_mode});
    end
    chk("sub_div", 1, {30'h0, sub_clock_div});
    rd(rf_a, 2, ok, "dt_flag");
    wr(rf_a, 0, ok);
    rd(rf_a, 0, ok, "dt_flag");
    $display("test modes done");
    tally_and_finish();
  end
endmodule
